/* File: hw/usbifl_top.v */
/*
  usb interrupt flag logic: latches serial engine status and error events as
  sticky flags, gates them with enables, drives the combined error flag and
  an interrupt request. assumes event inputs are one-cycle pulses from logic
  on CLK_SYS, and a bit-time enable pulse from the serial engine.
*/
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
// Functional notes
// - seven status enables: sof 6, stall 5, idle 4, trn 3, activity 2, error 1, reset 0
// - a set enable bit makes the matching status flag an interrupt source
// - enables only gate propagation, never flag setting
// - flags set by their condition even with enable clear
// - each error flag has its own enable in a separate enable register; the code lets any error flag raise IRQ whenever status enable bit 1 is set
// - combined error flag is OR of error flags
// - error flags set in the cycle the condition is detected
// - error bit 7 on bit-stuffing violation
// - error bit 4 on more than 16 idle bit times after end of packet
// - error bit 3 when data field is not whole bytes
// - error bit 2 on data CRC16 failure
// - error bit 1 and token rejected on CRC5 failure
// - status enable bit 7 and error bits 6 to 5 read zero
// - activity flag raised once per resume from idle
`timescale 1ns/10ps
`default_nettype none
`include "usbifl_defines.vh"

module usbifl_top
(
  input  wire        CLK_SYS,         // system clock, 10 MHz
  input  wire        RST,             // asynchronous reset, active high
  input  wire [4:0]  AVS_ADDRESS,     // word address
  input  wire        AVS_READ,        // read strobe
  input  wire        AVS_WRITE,       // write strobe
  input  wire [3:0]  AVS_BYTEENABLE,  // byte lanes
  input  wire [31:0] AVS_WRITEDATA,   // write data
  output reg  [31:0] AVS_READDATA,    // read data
  output reg         AVS_WAITREQUEST, // stall until answer
  output reg  [1:0]  AVS_RESPONSE,    // 00 ok, 10 slave error
  input  wire        EV_SOF,          // start-of-frame token seen
  input  wire        EV_STALL,        // stall handshake sent
  input  wire        EV_IDLE,         // bus idle detected
  input  wire        EV_TRN,          // transaction complete
  input  wire        EV_ACTIVITY,     // bus activity seen
  input  wire        EV_BUS_RESET,    // bus reset seen
  input  wire        EV_STUFF_ERR,    // bit stuffing violation
  input  wire        EV_EOP,          // end of packet
  input  wire        EV_RX_START,     // start of a received packet
  input  wire        BIT_TICK,        // one pulse per bit time
  input  wire        EV_PARTIAL_BYTE, // data field not whole bytes
  input  wire        EV_CRC16_FAIL,   // data crc failed
  input  wire        EV_CRC5_FAIL,    // token crc failed
  input  wire        EV_PID_FAIL,     // pid check failed
  output reg         TOKEN_REJECT,    // token dropped for crc5 error
  output reg         COMBINED_ERR,    // OR of error flags
  output reg         IRQ              // request to the processor
);

  parameter TURN_BITS = `USBIFL_TURN_BITS;

  reg  [7:0] usb_status_irq_flags_reg;
  reg  [7:0] usb_status_irq_flags_next;
  reg  [7:0] usb_status_irq_enable_reg;
  reg  [7:0] usb_error_status_flags_reg;
  reg  [7:0] usb_error_status_flags_next;
  reg  [7:0] usb_error_irq_enable_reg;
  reg        activity_armed_reg;
  reg        turn_wait_reg;
  reg  [5:0] turn_cnt_reg;
  reg        ack_reg;
  reg  [7:0] err_events;
  reg  [7:0] stat_events;
  reg  [7:0] rd_mux;
  wire       wr_lane0;
  wire       acc;
  wire       turn_to;
  wire       err_any_next;

  // W1 keeps, W0 clears; a set on the same cycle wins
  function [7:0] clear_zero;
    input [7:0] cur;
    input [7:0] wdata;
    input       wen;
    input [7:0] set;
    begin
      clear_zero = (wen ? (cur & wdata) : cur) | set;
    end
  endfunction

  function mapped;
    input [4:0] a;
    begin
      mapped = (a <= {1'b0, `USBIFL_IDX_LINK_STATE});
    end
  endfunction

  assign acc      = (AVS_READ | AVS_WRITE) & ~ack_reg;
  assign wr_lane0 = AVS_WRITE & ~ack_reg & AVS_BYTEENABLE[0];
  assign turn_to  = turn_wait_reg & BIT_TICK & (turn_cnt_reg == TURN_BITS[5:0]);

  always @*
  begin
    err_events = 8'h00;
    err_events[`USBIFL_B_BTS]   = EV_STUFF_ERR;
    err_events[`USBIFL_B_BTO]   = turn_to;
    err_events[`USBIFL_B_DFN8]  = EV_PARTIAL_BYTE;
    err_events[`USBIFL_B_CRC16] = EV_CRC16_FAIL;
    err_events[`USBIFL_B_CRC5]  = EV_CRC5_FAIL;
    err_events[`USBIFL_B_PID]   = EV_PID_FAIL;
  end

  always @*
  begin
    usb_error_status_flags_next = clear_zero(usb_error_status_flags_reg, AVS_WRITEDATA[7:0],
      wr_lane0 && AVS_ADDRESS == {1'b0, `USBIFL_IDX_ERR_FLAGS}, err_events) & `USBIFL_ERR_MASK;
  end

  assign err_any_next = |usb_error_status_flags_next;

  always @*
  begin
    stat_events = 8'h00;
    stat_events[`USBIFL_B_SOF]   = EV_SOF;
    stat_events[`USBIFL_B_STALL] = EV_STALL;
    stat_events[`USBIFL_B_IDLE]  = EV_IDLE;
    stat_events[`USBIFL_B_TRN]   = EV_TRN;
    stat_events[`USBIFL_B_ACTV]  = EV_ACTIVITY & activity_armed_reg;
    stat_events[`USBIFL_B_URST]  = EV_BUS_RESET;
    usb_status_irq_flags_next = clear_zero(usb_status_irq_flags_reg, AVS_WRITEDATA[7:0],
      wr_lane0 && AVS_ADDRESS == {1'b0, `USBIFL_IDX_STAT_FLAGS}, stat_events);
    // error summary follows the error flags
    usb_status_irq_flags_next[`USBIFL_B_UERR] = err_any_next;
    usb_status_irq_flags_next = usb_status_irq_flags_next & `USBIFL_STAT_MASK;
  end

  always @*
  begin
    case (AVS_ADDRESS)
      {1'b0, `USBIFL_IDX_STAT_FLAGS}: rd_mux = usb_status_irq_flags_reg;
      {1'b0, `USBIFL_IDX_STAT_EN}:    rd_mux = usb_status_irq_enable_reg & `USBIFL_STAT_MASK;
      {1'b0, `USBIFL_IDX_ERR_FLAGS}:  rd_mux = usb_error_status_flags_reg & `USBIFL_ERR_MASK;
      {1'b0, `USBIFL_IDX_ERR_EN}:     rd_mux = usb_error_irq_enable_reg & `USBIFL_ERR_MASK;
      {1'b0, `USBIFL_IDX_LINK_STATE}: rd_mux = {6'h00, turn_wait_reg, activity_armed_reg};
      default:                        rd_mux = 8'h00;
    endcase
  end

  always @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      usb_status_irq_flags_reg   <= `USBIFL_RST_VAL;
      usb_status_irq_enable_reg  <= `USBIFL_RST_VAL;
      usb_error_status_flags_reg <= `USBIFL_RST_VAL;
      usb_error_irq_enable_reg   <= `USBIFL_RST_VAL;
      activity_armed_reg         <= 1'b1;
      turn_wait_reg              <= 1'b0;
      turn_cnt_reg               <= 6'h00;
      ack_reg                    <= 1'b0;
      AVS_READDATA               <= 32'h00000000;
      AVS_WAITREQUEST            <= 1'b1;
      AVS_RESPONSE               <= 2'h0;
      TOKEN_REJECT               <= 1'b0;
      COMBINED_ERR               <= 1'b0;
      IRQ                        <= 1'b0;
    end
    else
    begin
      usb_status_irq_flags_reg   <= usb_status_irq_flags_next;
      usb_error_status_flags_reg <= usb_error_status_flags_next;
      if (wr_lane0 && AVS_ADDRESS == {1'b0, `USBIFL_IDX_STAT_EN})
        usb_status_irq_enable_reg <= AVS_WRITEDATA[7:0] & `USBIFL_STAT_MASK;
      if (wr_lane0 && AVS_ADDRESS == {1'b0, `USBIFL_IDX_ERR_EN})
        usb_error_irq_enable_reg <= AVS_WRITEDATA[7:0] & `USBIFL_ERR_MASK;
      if (EV_IDLE)
        activity_armed_reg <= 1'b1;
      else if (EV_ACTIVITY)
        activity_armed_reg <= 1'b0;
      if (EV_EOP)
      begin
        turn_wait_reg <= 1'b1;
        turn_cnt_reg  <= 6'h00;
      end
      else if (EV_RX_START || turn_to)
        turn_wait_reg <= 1'b0;
      else if (turn_wait_reg && BIT_TICK)
        turn_cnt_reg <= turn_cnt_reg + 6'h01;
      TOKEN_REJECT <= EV_CRC5_FAIL;
      COMBINED_ERR <= err_any_next;
      IRQ <= |((usb_status_irq_flags_next & usb_status_irq_enable_reg)
             | {7'h00, |(usb_error_status_flags_next & usb_error_irq_enable_reg)
                       & usb_status_irq_enable_reg[`USBIFL_B_UERR]});
      // one wait cycle, answer on the second
      ack_reg         <= acc;
      AVS_WAITREQUEST <= ~acc;
      AVS_RESPONSE    <= (acc && !mapped(AVS_ADDRESS)) ? 2'h2 : 2'h0;
      if (acc && AVS_READ)
        AVS_READDATA <= {24'h000000, rd_mux};
    end
  end

endmodule // usbifl_top
`default_nettype wire

/* File: hw/usbifl_defines.vh */
/*
  register offsets, field positions, reset values and timing counts of the
  usb interrupt flag logic. assumes a 10 MHz system clock.
*/
`ifndef USBIFL_DEFINES_VH
`define USBIFL_DEFINES_VH

// word offsets, byte address = 4 * index
`define USBIFL_IDX_STAT_FLAGS   4'h0
`define USBIFL_IDX_STAT_EN      4'h1
`define USBIFL_IDX_ERR_FLAGS    4'h2
`define USBIFL_IDX_ERR_EN       4'h3
`define USBIFL_IDX_LINK_STATE   4'h4

// status flag / enable positions
`define USBIFL_B_SOF            6
`define USBIFL_B_STALL          5
`define USBIFL_B_IDLE           4
`define USBIFL_B_TRN            3
`define USBIFL_B_ACTV           2
`define USBIFL_B_UERR           1
`define USBIFL_B_URST           0

// error flag positions
`define USBIFL_B_BTS            7
`define USBIFL_B_BTO            4
`define USBIFL_B_DFN8           3
`define USBIFL_B_CRC16          2
`define USBIFL_B_CRC5           1
`define USBIFL_B_PID            0

// implemented bit masks
`define USBIFL_STAT_MASK        8'h7F
`define USBIFL_ERR_MASK         8'h9F
`define USBIFL_RST_VAL          8'h00

// turnaround limit in bit times
`define USBIFL_TURN_BITS        16

`endif

/* File: dv/usbifl_monitor.sv */
/* port checker for usbifl_top.
   assumes one clock CLK_SYS and async reset RST. */
`timescale 1ns/10ps
`default_nettype none
module usbifl_monitor (
  input wire logic        CLK_SYS,         // clock
  input wire logic        RST,             // reset
  input wire logic        AVS_WRITE,       // write
  input wire logic        AVS_WAITREQUEST, // wait
  input wire logic [31:0] AVS_READDATA,    // read data
  input wire logic        EV_STUFF_ERR,    // stuff error
  input wire logic        EV_PID_FAIL,     // pid error
  input wire logic        EV_CRC5_FAIL,    // token crc error
  input wire logic        TOKEN_REJECT,    // token drop
  input wire logic        COMBINED_ERR     // error summary
);
  default clocking mcb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  a_token_reject: assert property (EV_CRC5_FAIL |=> TOKEN_REJECT)
    else $error("token kept after crc5 failure");
  a_reject_cause: assert property (TOKEN_REJECT |-> $past(EV_CRC5_FAIL))
    else $error("token dropped without cause");
  a_crc5_sets: assert property (EV_CRC5_FAIL |=> COMBINED_ERR)
    else $error("summary missed crc5 error");
  a_stuff_sets: assert property (EV_STUFF_ERR |=> COMBINED_ERR)
    else $error("summary missed stuff error");
  a_pid_sets: assert property (EV_PID_FAIL |=> COMBINED_ERR)
    else $error("summary missed pid error");
  a_err_sticky: assert property (COMBINED_ERR && !AVS_WRITE |=> COMBINED_ERR)
    else $error("error summary dropped by itself");
  a_clear_cause: assert property ($fell(COMBINED_ERR) |-> $past(AVS_WRITE))
    else $error("error summary fell without write");
  a_upper_zero: assert property (!AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h0)
    else $error("read data upper bits not zero");
endmodule // usbifl_monitor
bind usbifl_top usbifl_monitor mon (.CLK_SYS, .RST, .AVS_WRITE, .AVS_WAITREQUEST, .AVS_READDATA,
  .EV_STUFF_ERR, .EV_PID_FAIL, .EV_CRC5_FAIL, .TOKEN_REJECT, .COMBINED_ERR);
`default_nettype wire

/* File: dv/usbifl_sie_model.sv */
/* serial engine stand-in: one-cycle event pulses.
   assumes the bench calls pulse between its bus accesses. */
`timescale 1ns/10ps
`default_nettype none
module usbifl_sie_model (
  input  wire logic        clk, // system clock
  output var  logic [13:0] ev   // one bit per event source
);
  initial ev = 14'h0000;
  task automatic pulse(input logic [13:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 14'h0000;
  endtask
endmodule // usbifl_sie_model
`default_nettype wire

/* File: dv/usb_interrupt_flag_logic_test.sv */
/* bench for usbifl_top: avalon register tasks, events from the model.
   assumes one 10 MHz clock. */
`timescale 1ns/10ps
`default_nettype none
module usb_interrupt_flag_logic_test;
  logic        CLK_SYS = 1'b0;
  logic        RST = 1'b1;
  logic [4:0]  AVS_ADDRESS = 5'h00;
  logic [3:0]  AVS_BYTEENABLE = 4'hF;
  logic        AVS_READ = 1'b0;
  logic        AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [31:0] AVS_READDATA;
  logic [31:0] rdat;
  logic [1:0]  AVS_RESPONSE;
  logic        AVS_WAITREQUEST, TOKEN_REJECT, COMBINED_ERR, IRQ;
  logic [13:0] ev;
  wire logic   EV_SOF, EV_STALL, EV_IDLE, EV_TRN, EV_ACTIVITY, EV_BUS_RESET, EV_STUFF_ERR;
  wire logic   EV_EOP, EV_RX_START, BIT_TICK, EV_PARTIAL_BYTE, EV_CRC16_FAIL, EV_CRC5_FAIL, EV_PID_FAIL;
  int          fails = 0;
  int          check_count = 0;
  int          eb[5] = '{7, 3, 2, 1, 0};
  int          sb[6] = '{6, 5, 4, 3, 2, 0};
  assign {EV_SOF, EV_STALL, EV_IDLE, EV_TRN, EV_ACTIVITY, EV_BUS_RESET, EV_STUFF_ERR, EV_EOP,
    EV_RX_START, BIT_TICK, EV_PARTIAL_BYTE, EV_CRC16_FAIL, EV_CRC5_FAIL, EV_PID_FAIL} = ev;
  always #50 CLK_SYS = ~CLK_SYS;
  usbifl_sie_model sie (.clk(CLK_SYS), .ev(ev));
  usbifl_top dut (.CLK_SYS, .RST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_BYTEENABLE,
    .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST, .AVS_RESPONSE, .EV_SOF, .EV_STALL, .EV_IDLE,
    .EV_TRN, .EV_ACTIVITY, .EV_BUS_RESET, .EV_STUFF_ERR, .EV_EOP, .EV_RX_START, .BIT_TICK,
    .EV_PARTIAL_BYTE, .EV_CRC16_FAIL, .EV_CRC5_FAIL, .EV_PID_FAIL, .TOKEN_REJECT, .COMBINED_ERR, .IRQ);
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    AVS_ADDRESS <= a;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    AVS_WRITEDATA <= {24'h0, d};
    do
    begin
      @(posedge CLK_SYS);
      n++;
    end
    while (AVS_WAITREQUEST !== 1'b0 && n < 20);
    if (n >= 20)
    begin
      fails++;
      finish_test();
    end
    rdat = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, rdat, {24'h0, e});
  endtask
  initial
  begin
    repeat (3) @(posedge CLK_SYS);
    RST <= 1'b0;
    for (int i = 0; i < 4; i++)
      rchk("reset value", i[4:0], 8'h00);
    // a write without lane 0 must be ignored
    AVS_BYTEENABLE <= 4'hE;
    bus(1'b1, 5'h01, 8'hFF);
    AVS_BYTEENABLE <= 4'hF;
    rchk("lane0 off", 5'h01, 8'h00);
    bus(1'b1, 5'h01, 8'hFF);
    rchk("status enable", 5'h01, 8'h7F);
    bus(1'b1, 5'h01, 8'h00);
    foreach (eb[i])
    begin
      sie.pulse(14'h0001 << eb[i]);
      rchk("error flag", 5'h02, 8'h01 << eb[i]);
      chk("irq masked", IRQ, 1'b0);
      rchk("summary", 5'h00, 8'h02);
      bus(1'b1, 5'h02, 8'hFF);
      rchk("write one", 5'h02, 8'h01 << eb[i]);
      bus(1'b1, 5'h02, 8'h00);
      rchk("cleared", 5'h00, 8'h00);
    end
    bus(1'b1, 5'h03, 8'h9F);
    bus(1'b1, 5'h01, 8'h02);
    sie.pulse(14'h0004);
    rchk("crc16 flag", 5'h02, 8'h04);
    chk("error irq", IRQ, 1'b1);
    bus(1'b1, 5'h01, 8'h00);
    // request follows the enable one edge after the write lands
    @(posedge CLK_SYS);
    chk("error irq off", IRQ, 1'b0);
    bus(1'b1, 5'h02, 8'h00);
    foreach (sb[i])
    begin
      sie.pulse(14'h0001 << ((sb[i] == 0) ? 8 : sb[i] + 7));
      rchk("status flag", 5'h00, 8'h01 << sb[i]);
      chk("irq masked", IRQ, 1'b0);
      bus(1'b1, 5'h01, 8'h01 << sb[i]);
      @(posedge CLK_SYS);
      chk("irq enabled", IRQ, 1'b1);
      bus(1'b1, 5'h00, 8'h00);
      chk("irq cleared", IRQ, 1'b0);
      bus(1'b1, 5'h01, 8'h00);
    end
    sie.pulse(14'h0200);
    rchk("activity once", 5'h00, 8'h00);
    sie.pulse(14'h0800);
    sie.pulse(14'h0200);
    rchk("activity rearmed", 5'h00, 8'h14);
    // a new packet start cancels the turnaround wait
    sie.pulse(14'h0040);
    sie.pulse(14'h0020);
    repeat (17) sie.pulse(14'h0010);
    rchk("rx cancels", 5'h02, 8'h00);
    sie.pulse(14'h0040);
    repeat (16) sie.pulse(14'h0010);
    rchk("no timeout", 5'h02, 8'h00);
    sie.pulse(14'h0010);
    rchk("timeout", 5'h02, 8'h10);
    rchk("unmapped", 5'h05, 8'h00);
    chk("unmapped response", AVS_RESPONSE, 2'h2);
    finish_test();
  end
endmodule // usb_interrupt_flag_logic_test
`default_nettype wire
